/* serial_link_status_defines.svh */
// Register indices, field positions, reset values and widths of the serial link status block
// Functional notes
// RULE_01: Channel reg bits 0-3 show channel up
// RULE_02: Channel reg bit 4 set while user clock unlocked
// RULE_03: Channel reg bit 5 shows transceiver PLL lock
// RULE_04: Twelve lane-up bits, three per channel, ordered
// RULE_05: Four 20-bit soft error counts, upper bits zero
// RULE_06: Writing clear bit one zeroes all counters; the code loads 1 into a counter whose error pulse lands in the clear cycle
// RULE_07: Clear bit returns to zero by itself
// RULE_08: Clear bit always reads as zero
// RULE_09: Swing field bits 3:0, default 1001
// RULE_10: Post-cursor field bits 12:8, default zero
// RULE_11: Pre-cursor field bits 20:16, default zero
// RULE_12: Status inputs pass two flops before capture
`ifndef SERIAL_LINK_STATUS_DEFINES_SVH
`define SERIAL_LINK_STATUS_DEFINES_SVH

// Register indices on the host register port
`define IDX_INPUT_CHANNEL_STATE 4'h0
`define IDX_INPUT_LANE_STATE 4'h1
`define IDX_CHAN0_TALLY 4'h2
`define IDX_CHAN1_TALLY 4'h3
`define IDX_CHAN2_TALLY 4'h4
`define IDX_CHAN3_TALLY 4'h5
`define IDX_TALLY_CLEAR 4'h6
`define IDX_CHAN0_DRIVER_TUNING 4'h7

// Field layout
`define NUM_CHANNELS 4
`define NUM_LANES 12
`define TALLY_WIDTH 20
`define BIT_USER_CLOCK_UNLOCKED 4
`define BIT_XCVR_PLL0_LOCKED 5
`define BIT_TALLY_CLEAR 0
`define SWING_LSB 0
`define SWING_MSB 3
`define POST_LSB 8
`define POST_MSB 12
`define PRE_LSB 16
`define PRE_MSB 20

// Reset values and the tally saturation limit
`define SWING_RESET 4'h9
`define POST_RESET 5'h00
`define PRE_RESET 5'h00
`define TALLY_MAX 20'hfffff

`endif

/* serial_link_status_pkg.sv */
// Types shared by the serial link status register block
package serial_link_status_pkg;

  // Synchronised status of the serial input link
  typedef struct packed {
    logic [3:0] chan_link_up;
    logic [11:0] lane_link_up;
    logic user_clock_unlocked;
    logic xcvr_pll0_locked;
  } link_status_t;

  // Driver settings for the channel 0 mirror-array data outputs
  typedef struct packed {
    logic [3:0] chan0_data_swing;
    logic [4:0] chan0_data_post_emphasis;
    logic [4:0] chan0_data_pre_emphasis;
  } driver_tuning_t;

endpackage

/* serial_link_status_regs.sv */
// Status, soft error tally and driver tuning registers of the serial input link
`timescale 1ns/1ps
`include "serial_link_status_defines.svh"

module serial_link_status_regs
  import serial_link_status_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Link status levels, asynchronous to mclk
  input wire link_status_t link_status_pin,
  // Soft error pulses per channel, on mclk
  input wire logic [3:0] soft_error_event,
  // Host register port
  input wire logic [3:0] reg_index,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  // Driver settings toward the output transceivers
  output driver_tuning_t driver_tuning
);

  link_status_t sync1_q;
  link_status_t sync1_d;
  link_status_t sync2_q;
  link_status_t sync2_d;
  logic [`TALLY_WIDTH-1:0] tally_q [4];
  logic [`TALLY_WIDTH-1:0] tally_d [4];
  logic clear_pulse_q;
  logic clear_pulse_d;
  driver_tuning_t tuning_q;
  driver_tuning_t tuning_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;

  // Two-flop synchroniser; only stage two is read
  always_comb
  begin
    sync1_d = link_status_pin; // RULE_12
    sync2_d = sync1_q; // RULE_12
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  // Self-clearing clear strobe; lives one cycle after the write
  always_comb
  begin
    clear_pulse_d = reg_write && (reg_index == `IDX_TALLY_CLEAR)
      && reg_wdata[`BIT_TALLY_CLEAR]; // RULE_06 RULE_07
  end

  // Tallies saturate rather than wrap, so a flood never looks quiet
  always_comb
  begin
    for (int i = 0; i < `NUM_CHANNELS; i++)
    begin
      if (clear_pulse_q)
        tally_d[i] = {19'h0, soft_error_event[i]}; // RULE_06
      else if (soft_error_event[i] && (tally_q[i] != `TALLY_MAX))
        tally_d[i] = tally_q[i] + 20'h00001; // RULE_05
      else
        tally_d[i] = tally_q[i];
    end
  end

  // Driver settings, written as one word
  always_comb
  begin
    tuning_d = tuning_q;
    if (reg_write && (reg_index == `IDX_CHAN0_DRIVER_TUNING))
    begin
      tuning_d.chan0_data_swing = reg_wdata[`SWING_MSB:`SWING_LSB]; // RULE_09
      tuning_d.chan0_data_post_emphasis = reg_wdata[`POST_MSB:`POST_LSB]; // RULE_10
      tuning_d.chan0_data_pre_emphasis = reg_wdata[`PRE_MSB:`PRE_LSB]; // RULE_11
    end
  end

  // Read mux; data held between reads, unmapped indices read zero
  always_comb
  begin
    rdata_d = rdata_q;
    rvalid_d = reg_read;
    if (reg_read)
    begin
      rdata_d = 32'h00000000;
      case (reg_index)
        `IDX_INPUT_CHANNEL_STATE:
        begin
          rdata_d[3:0] = sync2_q.chan_link_up; // RULE_01
          rdata_d[`BIT_USER_CLOCK_UNLOCKED] = sync2_q.user_clock_unlocked; // RULE_02
          rdata_d[`BIT_XCVR_PLL0_LOCKED] = sync2_q.xcvr_pll0_locked; // RULE_03
        end
        `IDX_INPUT_LANE_STATE: rdata_d[11:0] = sync2_q.lane_link_up; // RULE_04
        `IDX_CHAN0_TALLY: rdata_d[19:0] = tally_q[0]; // RULE_05
        `IDX_CHAN1_TALLY: rdata_d[19:0] = tally_q[1];
        `IDX_CHAN2_TALLY: rdata_d[19:0] = tally_q[2];
        `IDX_CHAN3_TALLY: rdata_d[19:0] = tally_q[3];
        `IDX_TALLY_CLEAR: rdata_d = 32'h00000000; // RULE_08
        `IDX_CHAN0_DRIVER_TUNING:
        begin
          rdata_d[`SWING_MSB:`SWING_LSB] = tuning_q.chan0_data_swing;
          rdata_d[`POST_MSB:`POST_LSB] = tuning_q.chan0_data_post_emphasis;
          rdata_d[`PRE_MSB:`PRE_LSB] = tuning_q.chan0_data_pre_emphasis;
        end
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  // State registers
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < `NUM_CHANNELS; i++)
        tally_q[i] <= '0;
      clear_pulse_q <= 1'b0;
      tuning_q.chan0_data_swing <= `SWING_RESET; // RULE_09
      tuning_q.chan0_data_post_emphasis <= `POST_RESET; // RULE_10
      tuning_q.chan0_data_pre_emphasis <= `PRE_RESET; // RULE_11
      rdata_q <= 32'h00000000;
      rvalid_q <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < `NUM_CHANNELS; i++)
        tally_q[i] <= tally_d[i];
      clear_pulse_q <= clear_pulse_d;
      tuning_q <= tuning_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign driver_tuning = tuning_q;

  // Checks
  property p_chan_read;
    @(posedge mclk) disable iff (!nrst)
    reg_read && reg_index == `IDX_INPUT_CHANNEL_STATE
      |=> reg_rvalid && reg_rdata[3:0] == $past(sync2_q.chan_link_up);
  endproperty
  a_chan_read: assert property (p_chan_read) else $error("channel bits wrong"); // RULE_01

  property p_unlock_read;
    @(posedge mclk) disable iff (!nrst)
    reg_read && reg_index == `IDX_INPUT_CHANNEL_STATE
      |=> reg_rdata[4] == $past(link_status_pin.user_clock_unlocked, 3);
  endproperty
  a_unlock_read: assert property (p_unlock_read) else $error("unlock bit wrong"); // RULE_02

  property p_pll_read;
    @(posedge mclk) disable iff (!nrst)
    reg_read && reg_index == `IDX_INPUT_CHANNEL_STATE
      |=> reg_rdata[5] == $past(sync2_q.xcvr_pll0_locked) && reg_rdata[31:6] == 26'h0;
  endproperty
  a_pll_read: assert property (p_pll_read) else $error("pll bit wrong"); // RULE_03

  property p_lane_read;
    @(posedge mclk) disable iff (!nrst)
    reg_read && reg_index == `IDX_INPUT_LANE_STATE
      |=> reg_rdata == {20'h00000, $past(sync2_q.lane_link_up)};
  endproperty
  a_lane_read: assert property (p_lane_read) else $error("lane bits wrong"); // RULE_04

  property p_tally_count;
    @(posedge mclk) disable iff (!nrst)
    soft_error_event[1] && !clear_pulse_q && tally_q[1] != `TALLY_MAX
      |=> tally_q[1] == $past(tally_q[1]) + 20'h00001;
  endproperty
  a_tally_count: assert property (p_tally_count) else $error("tally missed event"); // RULE_05

  property p_tally_upper;
    @(posedge mclk) disable iff (!nrst)
    reg_read && reg_index == `IDX_CHAN2_TALLY |=> reg_rdata[31:20] == 12'h000;
  endproperty
  a_tally_upper: assert property (p_tally_upper) else $error("tally upper bits set"); // RULE_05

  property p_clear_all;
    @(posedge mclk) disable iff (!nrst)
    reg_write && reg_index == `IDX_TALLY_CLEAR && reg_wdata[0]
      |=> ##1 tally_q[0] <= 20'h1 && tally_q[1] <= 20'h1 && tally_q[2] <= 20'h1
        && tally_q[3] <= 20'h1;
  endproperty
  a_clear_all: assert property (p_clear_all) else $error("tallies not cleared"); // RULE_06

  property p_self_clear;
    @(posedge mclk) disable iff (!nrst)
    clear_pulse_q && !(reg_write && reg_index == `IDX_TALLY_CLEAR && reg_wdata[0])
      |=> !clear_pulse_q;
  endproperty
  a_self_clear: assert property (p_self_clear) else $error("clear bit stuck"); // RULE_07

  property p_clear_reads_zero;
    @(posedge mclk) disable iff (!nrst)
    reg_read && reg_index == `IDX_TALLY_CLEAR |=> reg_rdata == 32'h00000000;
  endproperty
  a_clear_reads_zero: assert property (p_clear_reads_zero) else $error("clear reg nonzero"); // RULE_08

  property p_tuning_write;
    @(posedge mclk) disable iff (!nrst)
    reg_write && reg_index == `IDX_CHAN0_DRIVER_TUNING
      |=> driver_tuning == {$past(reg_wdata[3:0]), $past(reg_wdata[12:8]),
        $past(reg_wdata[20:16])};
  endproperty
  a_tuning_write: assert property (p_tuning_write) else $error("tuning not written"); // RULE_09

  property p_tuning_hold;
    @(posedge mclk) disable iff (!nrst)
    !(reg_write && reg_index == `IDX_CHAN0_DRIVER_TUNING) |=> $stable(driver_tuning);
  endproperty
  a_tuning_hold: assert property (p_tuning_hold) else $error("tuning changed"); // RULE_10 RULE_11

  property p_sync_delay;
    @(posedge mclk) disable iff (!nrst)
    $past(nrst, 2) |-> sync2_q == $past(link_status_pin, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("sync depth wrong"); // RULE_12

  c_clear: cover property (@(posedge mclk) disable iff (!nrst) clear_pulse_q && tally_q[0] != 0);
  c_tally_sat: cover property (@(posedge mclk) disable iff (!nrst) tally_q[2] == `TALLY_MAX);
  c_tune: cover property (@(posedge mclk) disable iff (!nrst)
    reg_write && reg_index == `IDX_CHAN0_DRIVER_TUNING ##1 reg_read);

endmodule

/* link_source_model.sv */
// Behavioural far-end transmitter: link status levels and soft error pulses
`timescale 1ns/1ps

module link_source_model
  import serial_link_status_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Commands from the bench
  input wire link_status_t want_status,
  input wire logic [3:0] want_errors,
  // Toward the device
  output link_status_t link_status_pin,
  output logic [3:0] soft_error_event
);
  // Levels move off the clock edge, as an unrelated transmitter would
  initial link_status_pin = '0;
  always @(want_status)
    link_status_pin <= #37 want_status;
  // Error pulses copied from want_errors on the clock, one cycle later; quiet in reset
  always @(posedge mclk or negedge nrst)
    if (!nrst)
      soft_error_event <= 4'h0;
    else
      soft_error_event <= want_errors;
endmodule

/* testbench.sv */
// Self-checking bench for the serial link status registers
`timescale 1ns/1ps

module testbench;
  import serial_link_status_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  link_status_t want_status = '0;
  logic [3:0] want_errors = 4'h0;
  link_status_t link_status_pin;
  logic [3:0] soft_error_event;
  logic [3:0] reg_index = 4'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic reg_rvalid;
  driver_tuning_t driver_tuning;
  int num_errors = 0;
  int n_checks = 0;

  // 10 MHz clock
  always #50 mclk = ~mclk;

  serial_link_status_regs dut(.mclk(mclk), .nrst(nrst), .link_status_pin(link_status_pin),
    .soft_error_event(soft_error_event), .reg_index(reg_index), .reg_write(reg_write),
    .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .driver_tuning(driver_tuning));

  link_source_model far_end(.mclk(mclk), .nrst(nrst), .want_status(want_status),
    .want_errors(want_errors), .link_status_pin(link_status_pin),
    .soft_error_event(soft_error_event));

  // Verdict in one place, reached by the tests and the watchdog alike
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Compare one value, four-state
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One write strobe, held for a single edge
  task automatic wr(input logic [3:0] idx, input logic [31:0] data);
    @(posedge mclk);
    reg_write <= 1'b1;
    reg_index <= idx;
    reg_wdata <= data;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask

  // One read strobe; answer looked at once the following edge has landed
  task automatic rd(input logic [3:0] idx, input logic [31:0] exp);
    @(posedge mclk);
    reg_read <= 1'b1;
    reg_index <= idx;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1;
    chk("rvalid", {31'h0, reg_rvalid}, 32'h1);
    chk($sformatf("rdata idx %0d", idx), reg_rdata, exp);
  endtask

  // Watchdog, far beyond the hundred or so cycles the tests take
  initial
  begin
    repeat (2000) @(posedge mclk);
    num_errors++;
    complete_run;
  end

  // Test sequence
  initial
  begin
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    // Reset values, including the clear bit and an unmapped index
    for (int i = 0; i < 7; i++)
      rd(4'(i), 32'h0);
    rd(4'h7, 32'h9);
    rd(4'hc, 32'h0);
    chk("tuning", {18'h0, driver_tuning}, 32'h2400);
    // Whole-word writes; reserved bits must drop
    wr(4'h7, 32'hffffffff);
    rd(4'h7, 32'h001f1f0f);
    wr(4'h7, 32'h00150a03);
    rd(4'h7, 32'h00150a03);
    chk("tuning", {18'h0, driver_tuning}, {18'h0, 4'h3, 5'h0a, 5'h15});
    // Status levels through the synchroniser, two patterns
    @(posedge mclk);
    want_status <= {4'ha, 12'h5a3, 1'b1, 1'b1};
    repeat (4) @(posedge mclk);
    rd(4'h0, 32'h3a);
    rd(4'h1, 32'h5a3);
    want_status <= {4'h5, 12'ha5c, 1'b0, 1'b0};
    repeat (4) @(posedge mclk);
    wr(4'h0, 32'hffffffff);
    wr(4'h1, 32'hffffffff);
    rd(4'h0, 32'h05);
    rd(4'h1, 32'ha5c);
    // Channel i gets i+1 error pulses, some back to back
    for (int k = 0; k < 4; k++)
    begin
      @(posedge mclk);
      want_errors <= 4'hf << k;
    end
    @(posedge mclk);
    want_errors <= 4'h0;
    wr(4'h3, 32'h0);
    repeat (3) @(posedge mclk);
    for (int i = 0; i < 4; i++)
      rd(4'(2 + i), 32'(i + 1));
    // Clear all tallies with one write
    wr(4'h6, 32'h1);
    repeat (3) @(posedge mclk);
    for (int i = 0; i < 4; i++)
      rd(4'(2 + i), 32'h0);
    rd(4'h6, 32'h0);
    // Event in the clear cycle is kept, and channel 0 stays at zero
    @(posedge mclk);
    want_errors <= 4'h2;
    wr(4'h6, 32'h1);
    want_errors <= 4'h0;
    repeat (3) @(posedge mclk);
    rd(4'h3, 32'h1);
    rd(4'h2, 32'h0);
    complete_run;
  end
endmodule
